/* File: hdl/psc_cfg_pkg.sv */
// constants, types and register map of the packet serial channel config block
package psc_cfg_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_MODE       = 8'h84;
  localparam logic [7:0] IDX_PWR        = 8'h87;
  localparam logic [7:0] IDX_STATUS     = 8'hE9;
  localparam logic [7:0] IDX_BAUD       = 8'h94;
  localparam logic [7:0] IDX_ADDR0      = 8'h95;
  localparam logic [7:0] IDX_ADDR1      = 8'hA5;
  localparam logic [7:0] IDX_ADDR2      = 8'hB5;
  localparam logic [7:0] IDX_ADDR3      = 8'hC5;
  localparam logic [7:0] IDX_MASK0      = 8'hD5;
  localparam logic [7:0] IDX_MASK1      = 8'hE5;
  localparam logic [7:0] IDX_GAP        = 8'hA4;
  localparam logic [7:0] IDX_IRQ_EN     = 8'hC8;
  localparam logic [7:0] IDX_SLOT       = 8'hF5;
  localparam logic [7:0] IDX_IRQ_PRIO   = 8'hF8;
  localparam logic [7:0] REG_RESET      = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int MODE_PROTOCOL  = 0;
  localparam int MODE_PRE_LO    = 1;
  localparam int MODE_PRE_HI    = 2;
  localparam int MODE_CRC_TYPE  = 3;
  localparam int MODE_ADDR_LEN  = 4;
  localparam int MODE_CH_LO     = 5;
  localparam int MODE_CH_HI     = 6;
  localparam int MODE_EXT_TX    = 7;
  localparam int PWR_IDLE_FLAG  = 2;
  localparam int PWR_EXT_RX     = 3;
  localparam int SLOT_MSB       = 5;
  localparam int SLOT_DET       = 6;
  localparam int SLOT_JAM       = 7;
  localparam int IRQ_BITS       = 6;

  // ---------------------------------------------------------------
  // framing values
  // ---------------------------------------------------------------
  localparam logic [6:0]  PRE_LEN_00    = 7'h00;
  localparam logic [6:0]  PRE_LEN_01    = 7'h08;
  localparam logic [6:0]  PRE_LEN_10    = 7'h20;
  localparam logic [6:0]  PRE_LEN_11    = 7'h40;
  localparam logic [3:0]  CD_MARK_BITS  = 4'h2;
  localparam logic [7:0]  CD_MARK_PAT   = 8'h03;
  localparam logic [3:0]  FLAG_BITS     = 4'h8;
  localparam logic [7:0]  FLAG_PAT      = 8'h7E;
  localparam logic [5:0]  CRC16_LEN     = 6'h10;
  localparam logic [5:0]  CRC32_LEN     = 6'h20;
  localparam logic [31:0] CRC16_POLY    = 32'h0000_1021;
  localparam logic [31:0] CRC32_POLY    = 32'h04C1_1DB7;
  localparam int          BAUD_SHIFT    = 3;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CH_NORMAL  = 2'h0,
    CH_RAW_TX  = 2'h1,
    CH_RAW_RX  = 2'h2,
    CH_ALT_BO  = 2'h3
  } psc_chan_mode_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h1,
    TX_DATA = 3'h2,
    TX_JAM  = 3'h4
  } psc_tx_state_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
  } psc_rx_addr_t;

  typedef struct packed {
    logic valid;
    logic hit;
  } psc_accept_t;

  typedef struct packed {
    logic [IRQ_BITS-1:0] request;
    logic [IRQ_BITS-1:0] high_prio;
  } psc_irq_t;

  typedef struct packed {
    logic [6:0]  preamble_fill;
    logic [3:0]  marker_bits;
    logic [7:0]  marker_pattern;
    logic [5:0]  crc_len;
    logic [31:0] crc_poly;
  } psc_frame_cfg_t;

  typedef struct packed {
    psc_chan_mode_t chan_mode;
    logic           flag_framed;
    logic           idle_flags;
    logic [7:0]     gap_bits;
  } psc_mode_cfg_t;

  typedef struct packed {
    logic [5:0] slot;
    logic       participate;
    logic       deterministic;
    logic       jam_low;
  } psc_backoff_t;

endpackage

/* File: hdl/psc_addr_cmp.sv */
// masked address comparator
`timescale 1ns/1ps
module psc_addr_cmp #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] rx_value,
  input  wire logic [W-1:0] match_value,
  input  wire logic [W-1:0] dont_care,
  output      logic         hit
);

  // a one in dont_care removes that bit from the compare
  assign hit = (((rx_value ^ match_value) & ~dont_care) == {W{1'b0}});

endmodule

/* File: hdl/psc_channel_cfg.sv */
// packet serial channel configuration, clocking and line coding
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module psc_channel_cfg (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output      logic [31:0]                 prdata,
  output      logic                        pready,
  output      logic                        pslverr,
  input  wire logic                        tx_clock_input,
  input  wire logic                        rx_clock_input,
  input  wire logic                        channel_rx_pin,
  output      logic                        channel_tx_pin,
  input  wire logic                        tx_frame_active,
  input  wire logic                        tx_data_bit,
  input  wire logic                        tx_crc_bit,
  input  wire logic                        collision_seen,
  output      logic                        tx_bit_taken,
  output      logic                        rx_bit_tick,
  output      logic                        rx_data_sync,
  input  wire psc_cfg_pkg::psc_rx_addr_t   rx_addr,
  output      psc_cfg_pkg::psc_accept_t    addr_accept,
  input  wire logic [5:0]                  irq_events,
  output      psc_cfg_pkg::psc_irq_t       irq_out,
  output      psc_cfg_pkg::psc_frame_cfg_t frame_cfg,
  output      psc_cfg_pkg::psc_mode_cfg_t  mode_cfg,
  output      psc_cfg_pkg::psc_backoff_t   backoff_cfg
);
  import psc_cfg_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [7:0]     mode_ff;
  logic [7:0]     pwr_ff;
  logic [7:0]     baud_ff;
  logic [7:0]     addr_ff [0:3];
  logic [7:0]     mask_ff [0:1];
  logic [7:0]     gap_ff;
  logic [7:0]     irq_en_ff;
  logic [7:0]     slot_ff;
  logic [7:0]     irq_prio_ff;
  logic           pready_ff;
  logic           pslverr_ff;
  logic [31:0]    prdata_ff;
  logic [2:0]     pin_s1_ff;
  logic [2:0]     pin_s2_ff;
  logic [2:0]     pin_s3_ff;
  logic [11:0]    baud_cnt_ff;
  logic [11:0]    nxt_baud_cnt;
  psc_tx_state_t  tx_state_ff;
  psc_tx_state_t  nxt_tx_state;
  logic [5:0]     jam_cnt_ff;
  logic [2:0]     flag_idx_ff;
  logic           line_ff;
  logic           held_bit_ff;
  logic           tx_bit_taken_ff;
  logic           rx_bit_tick_ff;
  psc_accept_t    accept_ff;
  psc_irq_t       irq_ff;
  psc_frame_cfg_t frame_ff;
  psc_mode_cfg_t  mode_cfg_ff;
  psc_backoff_t   backoff_ff;
  logic [7:0]     idx;
  logic           idx_ok;
  logic [7:0]     rd_val;
  logic           wr_en;
  logic [8:0]     baud_plus;
  logic [11:0]    period;
  logic [11:0]    half;
  logic           int_full;
  logic           int_half;
  logic           tx_full;
  logic           tx_half;
  logic           rx_tick;
  logic           flag_framed;
  logic           cur_bit;
  logic [6:0]     pre_len;
  logic [3:0]     hit8;
  logic [1:0]     hit16;
  logic [7:0]     care8 [0:3];

  assign flag_framed = mode_ff[MODE_PROTOCOL];

  // ---------------------------------------------------------------
  // apb slave: one wait state, then pready for one cycle
  // ---------------------------------------------------------------
  assign idx   = paddr[9:2];
  assign wr_en = psel & penable & pwrite & pready_ff & idx_ok;

  always_comb
  begin
    idx_ok = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0);
    rd_val = 8'h00;
    unique case (idx)
      IDX_MODE:     rd_val = mode_ff;
      IDX_PWR:      rd_val = pwr_ff;
      IDX_BAUD:     rd_val = baud_ff;
      IDX_ADDR0:    rd_val = addr_ff[0];
      IDX_ADDR1:    rd_val = addr_ff[1];
      IDX_ADDR2:    rd_val = addr_ff[2];
      IDX_ADDR3:    rd_val = addr_ff[3];
      IDX_MASK0:    rd_val = mask_ff[0];
      IDX_MASK1:    rd_val = mask_ff[1];
      IDX_GAP:      rd_val = gap_ff;
      IDX_IRQ_EN:   rd_val = irq_en_ff;
      IDX_SLOT:     rd_val = slot_ff;
      IDX_IRQ_PRIO: rd_val = irq_prio_ff;
      IDX_STATUS:   rd_val = {tx_state_ff, line_ff, pin_s2_ff[2], accept_ff.hit,
                              accept_ff.valid, 1'b0};
      default:      idx_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      pready_ff <= psel & penable & ~pready_ff;
      if (psel & penable & ~pready_ff)
      begin
        pslverr_ff <= ~idx_ok;
        prdata_ff  <= (idx_ok && !pwrite) ? {24'h00_0000, rd_val} : 32'h0000_0000;
      end
      else
      begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // all zero after reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_ff     <= REG_RESET;
      pwr_ff      <= REG_RESET;
      baud_ff     <= REG_RESET;
      addr_ff     <= '{REG_RESET, REG_RESET, REG_RESET, REG_RESET};
      mask_ff     <= '{REG_RESET, REG_RESET};
      gap_ff      <= REG_RESET;
      irq_en_ff   <= REG_RESET;
      slot_ff     <= REG_RESET;
      irq_prio_ff <= REG_RESET;
    end
    else if (wr_en)
    begin
      unique case (idx)
        IDX_MODE:     mode_ff     <= pwdata[7:0];
        IDX_PWR:      pwr_ff      <= pwdata[7:0];
        IDX_BAUD:     baud_ff     <= pwdata[7:0];
        IDX_ADDR0:    addr_ff[0]  <= pwdata[7:0];
        IDX_ADDR1:    addr_ff[1]  <= pwdata[7:0];
        IDX_ADDR2:    addr_ff[2]  <= pwdata[7:0];
        IDX_ADDR3:    addr_ff[3]  <= pwdata[7:0];
        IDX_MASK0:    mask_ff[0]  <= pwdata[7:0];
        IDX_MASK1:    mask_ff[1]  <= pwdata[7:0];
        IDX_GAP:      gap_ff      <= pwdata[7:0];
        IDX_IRQ_EN:   irq_en_ff   <= {2'h0, pwdata[5:0]};
        IDX_SLOT:     slot_ff     <= pwdata[7:0];
        IDX_IRQ_PRIO: irq_prio_ff <= {2'h0, pwdata[5:0]};
        default:      ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers: 0 tx clock, 1 rx clock, 2 rx data
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1_ff <= 3'h0;
      pin_s2_ff <= 3'h0;
      pin_s3_ff <= 3'h0;
    end
    else
    begin
      pin_s1_ff <= {channel_rx_pin, rx_clock_input, tx_clock_input};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  // ---------------------------------------------------------------
  // baud generator and clock selection
  // ---------------------------------------------------------------
  // period is eight times baud plus one
  assign baud_plus = {1'b0, baud_ff} + 9'h001;
  assign period    = {baud_plus, 3'h0};
  assign half      = {1'b0, baud_plus, 2'h0};
  // a counter left above a shortened period wraps at once
  assign int_full  = (baud_cnt_ff >= period - 12'h001);
  assign int_half  = (baud_cnt_ff == half - 12'h001);
  assign nxt_baud_cnt = int_full ? 12'h000 : baud_cnt_ff + 12'h001;

  assign tx_full = mode_ff[MODE_EXT_TX] ? (pin_s2_ff[0] & ~pin_s3_ff[0]) : int_full;
  assign tx_half = mode_ff[MODE_EXT_TX] ? (~pin_s2_ff[0] & pin_s3_ff[0]) : int_half;
  assign rx_tick = pwr_ff[PWR_EXT_RX] ? (pin_s2_ff[1] & ~pin_s3_ff[1]) : int_full;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      baud_cnt_ff    <= 12'h000;
      rx_bit_tick_ff <= 1'b0;
    end
    else
    begin
      baud_cnt_ff    <= nxt_baud_cnt;
      rx_bit_tick_ff <= rx_tick;
    end
  end

  // ---------------------------------------------------------------
  // transmit sequencer: data, collision jam, idle fill
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_tx_state = tx_state_ff;
    unique case (tx_state_ff)
      TX_IDLE:
      begin
        if (collision_seen && !flag_framed)
          nxt_tx_state = TX_JAM;
        else if (tx_frame_active)
          nxt_tx_state = TX_DATA;
      end
      TX_DATA:
      begin
        if (collision_seen && !flag_framed)
          nxt_tx_state = TX_JAM;
        else if (!tx_frame_active)
          nxt_tx_state = TX_IDLE;
      end
      TX_JAM:
      begin
        if (tx_full && (jam_cnt_ff == frame_ff.crc_len - 6'h01))
          nxt_tx_state = TX_IDLE;
      end
    endcase
  end

  always_comb
  begin
    cur_bit = 1'b1;
    unique case (tx_state_ff)
      TX_DATA: cur_bit = tx_data_bit;
      TX_JAM:  cur_bit = backoff_ff.jam_low ? 1'b0 : ~tx_crc_bit;
      TX_IDLE: cur_bit = mode_cfg_ff.idle_flags ? FLAG_PAT[3'h7 - flag_idx_ff] : 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_state_ff <= TX_IDLE;
      jam_cnt_ff  <= 6'h00;
      flag_idx_ff <= 3'h0;
    end
    else
    begin
      tx_state_ff <= nxt_tx_state;
      if (tx_state_ff != TX_JAM)
        jam_cnt_ff <= 6'h00;
      else if (tx_full)
        jam_cnt_ff <= jam_cnt_ff + 6'h01;
      if (tx_state_ff != TX_IDLE || !mode_cfg_ff.idle_flags)
        flag_idx_ff <= 3'h0;
      else if (tx_full)
        flag_idx_ff <= flag_idx_ff + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // line coder
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_ff         <= 1'b1;
      held_bit_ff     <= 1'b1;
      tx_bit_taken_ff <= 1'b0;
    end
    else
    begin
      tx_bit_taken_ff <= tx_full && (tx_state_ff == TX_DATA);
      if (tx_full)
      begin
        held_bit_ff <= cur_bit;
        if (mode_cfg_ff.chan_mode == CH_RAW_TX)
          line_ff <= cur_bit;
        else if (flag_framed)
          line_ff <= cur_bit ? line_ff : ~line_ff;
        // manchester first half is the inverted bit
        else
          line_ff <= ~cur_bit;
      end
      else if (tx_half && !flag_framed && mode_cfg_ff.chan_mode != CH_RAW_TX)
      begin
        line_ff <= held_bit_ff;
      end
    end
  end

  // ---------------------------------------------------------------
  // address filter
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_byte
      if (g < 2)
      begin : g_masked
        assign care8[g] = mask_ff[g];
      end
      else
      begin : g_plain
        assign care8[g] = 8'h00;
      end
      // byte compare, masks on first two
      psc_addr_cmp #(.W(8)) u_cmp8 (
        .rx_value    (rx_addr.addr[7:0]),
        .match_value (addr_ff[g]),
        .dont_care   (care8[g]),
        .hit         (hit8[g])
      );
    end
    for (g = 0; g < 2; g++)
    begin : g_pair
      // pair compare, mask on first pair only
      psc_addr_cmp #(.W(16)) u_cmp16 (
        .rx_value    (rx_addr.addr),
        .match_value ({addr_ff[2*g+1], addr_ff[2*g]}),
        .dont_care   ((g == 0) ? {mask_ff[1], mask_ff[0]} : 16'h0000),
        .hit         (hit16[g])
      );
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      accept_ff <= '0;
    end
    else
    begin
      accept_ff.valid <= rx_addr.valid;
      if (rx_addr.valid)
      begin
        if (mode_ff[MODE_ADDR_LEN])
          accept_ff.hit <= (&rx_addr.addr) | (|hit16);
        else
          accept_ff.hit <= (&rx_addr.addr[7:0]) | (|hit8);
      end
    end
  end

  // ---------------------------------------------------------------
  // derived configuration
  // ---------------------------------------------------------------
  always_comb
  begin
    unique case ({mode_ff[MODE_PRE_HI], mode_ff[MODE_PRE_LO]})
      2'h0: pre_len = PRE_LEN_00;
      2'h1: pre_len = PRE_LEN_01;
      2'h2: pre_len = PRE_LEN_10;
      2'h3: pre_len = PRE_LEN_11;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_ff    <= '0;
      mode_cfg_ff <= '{CH_NORMAL, 1'b0, 1'b0, 8'h00};
      backoff_ff  <= '0;
      irq_ff      <= '0;
    end
    else
    begin
      if (flag_framed)
      begin
        frame_ff.preamble_fill  <= pre_len;
        frame_ff.marker_bits    <= FLAG_BITS;
        frame_ff.marker_pattern <= FLAG_PAT;
      end
      else
      begin
        // zero length unusable here, held at zero
        frame_ff.preamble_fill  <= (pre_len == PRE_LEN_00) ? PRE_LEN_00
                                   : pre_len - {3'h0, CD_MARK_BITS};
        frame_ff.marker_bits    <= CD_MARK_BITS;
        frame_ff.marker_pattern <= CD_MARK_PAT;
      end
      frame_ff.crc_len  <= mode_ff[MODE_CRC_TYPE] ? CRC32_LEN : CRC16_LEN;
      frame_ff.crc_poly <= mode_ff[MODE_CRC_TYPE] ? CRC32_POLY : CRC16_POLY;
      mode_cfg_ff.chan_mode   <= psc_chan_mode_t'(mode_ff[MODE_CH_HI:MODE_CH_LO]);
      mode_cfg_ff.flag_framed <= flag_framed;
      // idle flags only in flag mode
      mode_cfg_ff.idle_flags  <= pwr_ff[PWR_IDLE_FLAG] & flag_framed;
      mode_cfg_ff.gap_bits    <= gap_ff;
      // slot zero stays out of backoff
      backoff_ff.slot          <= slot_ff[SLOT_MSB:0];
      backoff_ff.participate   <= (slot_ff[SLOT_MSB:0] != 6'h00);
      backoff_ff.deterministic <= slot_ff[SLOT_DET];
      backoff_ff.jam_low       <= slot_ff[SLOT_JAM];
      irq_ff.request   <= irq_events & irq_en_ff[IRQ_BITS-1:0];
      irq_ff.high_prio <= irq_events & irq_en_ff[IRQ_BITS-1:0]
                          & irq_prio_ff[IRQ_BITS-1:0];
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata         = prdata_ff;
  assign pready         = pready_ff;
  assign pslverr        = pslverr_ff;
  assign channel_tx_pin = line_ff;
  assign tx_bit_taken   = tx_bit_taken_ff;
  assign rx_bit_tick    = rx_bit_tick_ff;
  assign rx_data_sync   = pin_s3_ff[2];
  assign addr_accept    = accept_ff;
  assign irq_out        = irq_ff;
  assign frame_cfg      = frame_ff;
  assign mode_cfg       = mode_cfg_ff;
  assign backoff_cfg    = backoff_ff;

endmodule

/* File: bench/psc_channel_cfg_monitor.sv */
// port checker of the packet serial channel config block
`timescale 1ns/1ps
module psc_channel_cfg_monitor (
  input wire logic                        pclk,
  input wire logic                        presetn,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pready,
  input wire psc_cfg_pkg::psc_rx_addr_t   rx_addr,
  input wire psc_cfg_pkg::psc_accept_t    addr_accept,
  input wire logic [5:0]                  irq_events,
  input wire psc_cfg_pkg::psc_irq_t       irq_out,
  input wire psc_cfg_pkg::psc_frame_cfg_t frame_cfg,
  input wire psc_cfg_pkg::psc_mode_cfg_t  mode_cfg,
  input wire psc_cfg_pkg::psc_backoff_t   backoff_cfg
);
  import psc_cfg_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_wait; psel && penable && !pready; endsequence
  property p_ans; s_setup ##1 s_wait |=> pready ##1 !pready; endproperty
  a_ans: assert property (p_ans) else $error("apb answer not one pulse");
  property p_bcast; rx_addr.valid && (&rx_addr.addr) |=> addr_accept.hit; endproperty
  a_bcast: assert property (p_bcast) else $error("all ones refused");
  property p_acc; addr_accept.valid == $past(rx_addr.valid); endproperty
  a_acc: assert property (p_acc) else $error("accept timing");
  property p_irq; (irq_out.request & ~$past(irq_events)) == 6'h00; endproperty
  a_irq: assert property (p_irq) else $error("request without event");
  property p_prio; (irq_out.high_prio & ~irq_out.request) == 6'h00; endproperty
  a_prio: assert property (p_prio) else $error("priority without request");
  property p_crc;
    frame_cfg.crc_len == CRC32_LEN |-> frame_cfg.crc_poly == CRC32_POLY;
  endproperty
  a_crc: assert property (p_crc) else $error("crc pairing");
  property p_mark; mode_cfg.flag_framed |-> frame_cfg.marker_pattern == FLAG_PAT; endproperty
  a_mark: assert property (p_mark) else $error("marker not flag");
  property p_slot; backoff_cfg.participate == (backoff_cfg.slot != 6'h00); endproperty
  a_slot: assert property (p_slot) else $error("slot participation");
endmodule
bind psc_channel_cfg psc_channel_cfg_monitor i_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .rx_addr(rx_addr),
  .addr_accept(addr_accept), .irq_events(irq_events), .irq_out(irq_out),
  .frame_cfg(frame_cfg), .mode_cfg(mode_cfg), .backoff_cfg(backoff_cfg));

/* File: bench/psc_peer_model.sv */
// peer station: bit clocks and line data; clocks stop outside frames, line data is random every fourth cycle in frames, toggles every cycle outside
`timescale 1ns/1ps
module psc_peer_model (
  input  wire logic pclk,
  input  wire logic active,
  output      logic tx_clk,
  output      logic rx_clk,
  output      logic rx_pin
);
  logic [3:0] div_ff = 4'h0;
  initial
  begin
    tx_clk = 1'b0;
    rx_clk = 1'b0;
    rx_pin = 1'b1;
  end
  // clocks stand still between frames
  always @(posedge pclk)
  begin
    div_ff <= active ? div_ff + 4'h1 : 4'h0;
    tx_clk <= active & div_ff[3];
    rx_clk <= active & div_ff[2];
    rx_pin <= active ? ((div_ff[1:0] == 2'h0) ? 1'($urandom) : rx_pin) : !rx_pin;
  end
endmodule

/* File: bench/psc_channel_cfg_tb_top.sv */
// self-checking bench of the packet serial channel config block
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module psc_channel_cfg_tb_top;
  import psc_cfg_pkg::*;
  localparam logic [7:0] RW_IDX [13] = '{IDX_MODE, IDX_PWR, IDX_BAUD, IDX_ADDR0, IDX_ADDR1,
    IDX_ADDR2, IDX_ADDR3, IDX_MASK0, IDX_MASK1, IDX_GAP, IDX_IRQ_EN, IDX_SLOT, IDX_IRQ_PRIO};
  localparam logic [6:0] PL [4] = '{PRE_LEN_00, PRE_LEN_01, PRE_LEN_10, PRE_LEN_11};
  localparam logic [7:0] BO [4] = '{8'h00, 8'h81, 8'h7F, 8'hC0};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, tx_act, tx_bit, peer_on;
  logic tx_clk, rx_clk, rx_pin, taken, rx_tick, tx_line, rx_sync, tb1, ln1;
  logic [2:0] rs;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] en, pr, rm [256] = '{default: 8'h00};
  logic [5:0] ev;
  logic [9:0] q [$], e;
  logic [1:0] qa [$], ea;
  psc_rx_addr_t rxa;
  psc_accept_t acc;
  psc_irq_t irq;
  psc_frame_cfg_t fc;
  psc_mode_cfg_t mc;
  psc_backoff_t bo;
  int errors, check_count, cyc, ticks, takes, sp, bp;
  psc_channel_cfg i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_clock_input(tx_clk), .rx_clock_input(rx_clk),
    .channel_rx_pin(rx_pin), .channel_tx_pin(tx_line), .tx_frame_active(tx_act),
    .tx_data_bit(tx_bit), .tx_crc_bit(1'b0), .collision_seen(1'b0), .tx_bit_taken(taken),
    .rx_bit_tick(rx_tick), .rx_data_sync(rx_sync), .rx_addr(rxa), .addr_accept(acc),
    .irq_events(ev), .irq_out(irq), .frame_cfg(fc), .mode_cfg(mc), .backoff_cfg(bo));
  psc_peer_model i_peer (.pclk(pclk), .active(peer_on), .tx_clk(tx_clk),
    .rx_clk(rx_clk), .rx_pin(rx_pin));
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic rg(input logic w, input logic [7:0] i, input logic [7:0] d);
    logic err;
    err = !(i inside {RW_IDX, IDX_STATUS});
    if (w && !err)
      rm[i] = d & ((i == IDX_IRQ_EN || i == IDX_IRQ_PRIO) ? 8'h3F : 8'hFF);
    q.push_back({w, err, err ? 8'h00 : rm[i]});
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, 2'b00, i, 2'b00, 24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  task automatic chk_addr(input logic [15:0] a, input logic h);
    @(posedge pclk);
    rxa <= '{1'b1, a};
    qa.push_back({1'b1, h});
    @(posedge pclk);
    rxa.valid <= 1'b0;
  endtask
  always @(posedge pclk)
    if (acc.valid === 1'b1)
    begin
      ea = qa.pop_front();
      `CHK("accept", ea, acc)
    end
  always @(posedge pclk)
    if (pready === 1'b1)
    begin
      e = q.pop_front();
      `CHK("pslverr", e[8], pslverr)
      if (!e[9])
        `CHK("prdata", {24'h0, e[7:0]}, prdata)
    end
  always @(posedge pclk)
  begin
    cyc++;
    ticks += int'(rx_tick === 1'b1);
    takes += int'(taken === 1'b1);
    if (cyc > 12)
      `CHK("rxsync", rs[2], rx_sync)
    rs = {rs[1:0], rx_pin};
    if (tx_act !== 1'b1)
      sp = -999;
    sp++;
    if (taken === 1'b1)
    begin
      if (sp > 0)
        `CHK("period", bp, sp)
      `CHK("nrzi", tb1 ? ln1 : ~ln1, tx_line)
      sp = 0;
    end
    {tb1, ln1} = {tx_bit, tx_line};
    tx_bit <= 1'($urandom);
    if (cyc == 20000)
    begin
      errors++;
      wrap_up();
    end
  end
  initial
  begin
    void'($urandom(62));
    {presetn, psel, penable, pwrite, tx_act, tx_bit, peer_on, paddr, pwdata} = '0;
    rxa = '0;
    ev = '0;
    wt(6);
    presetn <= 1'b1;
    foreach (RW_IDX[k]) rg(0, RW_IDX[k], 8'h00);
    rg(1, 8'h10, 8'h5A);
    rg(0, 8'h10, 8'h00);
    // software keeps the mode protocol bit set, so random writes stay in flag framing
    foreach (RW_IDX[k])
      if (RW_IDX[k] != IDX_PWR)
      begin
        rg(1, RW_IDX[k], 8'($urandom) | {7'h0, RW_IDX[k] == IDX_MODE});
        rg(0, RW_IDX[k], 8'h00);
      end
    for (int i = 0; i < 16; i++)
      if (i[0] || i[2:1] != 2'h0)
      begin
        rg(1, IDX_MODE, 8'(i));
        wt(2);
        `CHK("pre", i[0] ? PL[i[2:1]] : PL[i[2:1]] - 7'h02, fc.preamble_fill)
        `CHK("mark", i[0] ? FLAG_BITS : CD_MARK_BITS, fc.marker_bits)
        `CHK("crc", i[3] ? CRC32_POLY : CRC16_POLY, fc.crc_poly)
        `CHK("proto", i[0], mc.flag_framed)
      end
    for (int i = 0; i < 4; i++)
    begin
      rg(1, IDX_MODE, 8'(i << 5) | 8'h01);
      wt(2);
      `CHK("chan", 2'(i), mc.chan_mode)
    end
    rg(1, IDX_ADDR0, 8'h12);
    rg(1, IDX_MASK0, 8'h0F);
    rg(1, IDX_ADDR1, 8'h34);
    rg(1, IDX_ADDR2, 8'h60);
    rg(1, IDX_ADDR3, 8'h55);
    rg(1, IDX_MASK1, 8'h00);
    chk_addr(16'h001A, 1'b1);
    chk_addr(16'h0055, 1'b1);
    chk_addr(16'h0022, 1'b0);
    chk_addr(16'hFFFF, 1'b1);
    rg(1, IDX_MODE, 8'h11);
    wt(2);
    chk_addr(16'h341F, 1'b1);
    chk_addr(16'h5560, 1'b1);
    chk_addr(16'h556F, 1'b0);
    chk_addr(16'h0012, 1'b0);
    repeat (4)
    begin
      en = 8'($urandom);
      pr = 8'($urandom);
      rg(1, IDX_IRQ_EN, en);
      rg(1, IDX_IRQ_PRIO, pr);
      ev <= 6'($urandom);
      wt(2);
      `CHK("irq", {ev & en[5:0], ev & en[5:0] & pr[5:0]}, irq)
    end
    foreach (BO[k])
    begin
      rg(1, IDX_SLOT, BO[k]);
      wt(2);
      `CHK("slot", {BO[k][5:0], BO[k][5:0] != 6'h00, BO[k][6], BO[k][7]}, bo)
    end
    rg(1, IDX_GAP, 8'hA5);
    rg(1, IDX_PWR, 8'h04);
    wt(2);
    `CHK("gap", 8'hA5, mc.gap_bits)
    `CHK("idle", 1'b1, mc.idle_flags)
    rg(1, IDX_BAUD, 8'h03);
    bp = 32;
    tx_act <= 1'b1;
    wt(200);
    tx_act <= 1'b0;
    rg(1, IDX_MODE, 8'h91);
    rg(1, IDX_PWR, 8'h0C);
    {ticks, takes} = '0;
    bp = 16;
    {peer_on, tx_act} <= 2'b11;
    wt(200);
    {peer_on, tx_act} <= 2'b00;
    `CHK("rxclk", 1'b1, ticks > 0)
    `CHK("txclk", 1'b1, takes > 0)
    wt(4);
    wrap_up();
  end
endmodule
